// [common/pir_pkg.sv]
// package for the identification and interrupt flag register bank
// assumes a single 10 MHz clock and a byte-wide internal register port
package pir_pkg;

    // register offsets on the internal byte port
    localparam logic [7:0] ADDR_PART_LOW  = 8'h00;
    localparam logic [7:0] ADDR_REV_VAR   = 8'h01;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h02;

    // interrupt flag bit positions
    localparam int BIT_FAULT    = 7;
    localparam int BIT_SHUTDOWN = 3;
    localparam int BIT_HOT_DIE  = 0;

    // reset values, zero byte and the mask of writable flag bits
    localparam logic [7:0] IRQ_RESET   = 8'h00;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic [7:0] IRQ_WR_MASK = 8'h89;

    // identification image as loaded from one-time-programmable memory
    typedef struct packed {
        logic [1:0]  silicon_revision;
        logic [1:0]  config_variant;
        logic [11:0] part_number;
    } pir_id_s;

    localparam pir_id_s ID_RESET = '0;

    // configuration variant letters, one per code
    typedef enum logic [1:0] {
        PIR_VAR_A = 2'h0,
        PIR_VAR_B = 2'h1,
        PIR_VAR_C = 2'h2,
        PIR_VAR_D = 2'h3
    } pir_variant_e;

    // device events, one-cycle pulses or levels sampled every clock
    typedef struct packed {
        logic rail_fault;
        logic die_critical;
        logic die_hot;
        logic shutdown;
    } pir_event_s;

endpackage

// [core/pir_regs.sv]
// identification registers and interrupt flag register of the power manager
// assumes the serial target engine presents byte reads and writes synchronously
// events arrive as active-high levels synchronous to sys_clk
`timescale 1ns/10ps

// How it works
// - offset 00h reads part number bits 7:0
// - offset 01h reads revision, variant, part high
// - variant code 0..3 names letter A..D
// - flag register at 02h resets to zero
// - fault bit7, shutdown bit3, hot die bit0
// - flags stick until host writes one
// - rail fault or critical sets fault; hot crossing sets bit0
// - id fields load from otp after reset
module pir_regs (
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    input  wire logic                otp_valid,
    input  wire pir_pkg::pir_id_s    otp_id,
    input  wire pir_pkg::pir_event_s dev_event,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    output logic      [7:0]          irq_flags,
    output logic      [1:0]          variant_code
);

    // latched identification image
    pir_pkg::pir_id_s id_q;
    // have we already captured the otp image
    logic             id_loaded_q;
    // sticky flag register
    logic [7:0]       irq_q;
    logic [7:0]       irq_d;
    // read data holding register
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    // previous hot-die level for crossing detection
    logic             hot_prev_q;

    // decode of one offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // one select per mapped offset
    wire logic       sel_low  = hit(reg_addr, pir_pkg::ADDR_PART_LOW);
    wire logic       sel_rev  = hit(reg_addr, pir_pkg::ADDR_REV_VAR);
    wire logic       sel_irq  = hit(reg_addr, pir_pkg::ADDR_IRQ_FLAGS);
    // write-one-clear strobes, only on writable flag bits
    wire logic [7:0] clr_mask = (reg_wr && sel_irq) ? (reg_wdata & pir_pkg::IRQ_WR_MASK) : pir_pkg::ZERO_BYTE;
    // rising above the hot threshold, not the level itself
    wire logic       hot_rise = dev_event.die_hot && !hot_prev_q;

    // set terms per flag bit
    logic [7:0] set_mask;
    always_comb begin
        set_mask                        = pir_pkg::ZERO_BYTE;
        set_mask[pir_pkg::BIT_FAULT]    = dev_event.rail_fault || dev_event.die_critical;
        set_mask[pir_pkg::BIT_SHUTDOWN] = dev_event.shutdown;
        set_mask[pir_pkg::BIT_HOT_DIE]  = hot_rise;
    end

    // set beats clear so an event in the clearing cycle is kept
    // final mask keeps reserved positions at zero whatever the set terms say
    assign irq_d = ((irq_q & ~clr_mask) | set_mask) & pir_pkg::IRQ_WR_MASK;

    // byte image of each mapped offset
    wire logic [7:0] img_low = id_q.part_number[7:0];
    wire logic [7:0] img_rev = {id_q.silicon_revision, id_q.config_variant, id_q.part_number[11:8]};
    // reserved flag bits are already held at zero in irq_q
    wire logic [7:0] img_irq = irq_q;
    // offset select; unmapped offsets read zero
    wire logic [7:0] rd_sel  = sel_low ? img_low :
                               sel_rev ? img_rev :
                               sel_irq ? img_irq : pir_pkg::ZERO_BYTE;
    // only a read strobe moves the read byte, so it stands until the next read
    assign rdata_d = reg_rd ? rd_sel : rdata_q;

    // flag register and hot edge history
    // a die already hot at release counts as a crossing, which errs on the safe side
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // all flags clear on reset
            irq_q      <= pir_pkg::IRQ_RESET;
            hot_prev_q <= 1'h0;
        end else begin
            // next flags already carry set, clear and reserved masking
            irq_q      <= irq_d;
            hot_prev_q <= dev_event.die_hot;
        end
    end

    // otp capture after reset release; a strap-like level so clocked, not reset-loaded
    // only the first valid cycle counts, so later activity on the otp lines cannot alter the id
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // id reads zero until the otp image arrives
            id_q        <= pir_pkg::ID_RESET;
            id_loaded_q <= 1'h0;
        end else if (otp_valid && !id_loaded_q) begin
            // first valid cycle after release
            id_q        <= otp_id;
            id_loaded_q <= 1'h1;
        end
    end

    // read data register, so the read byte leaves straight from a flip-flop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // nothing read yet
            rdata_q <= pir_pkg::ZERO_BYTE;
        end else begin
            // holds unless a read strobe came
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata    = rdata_q;
    assign irq_flags    = irq_q;
    // code 0..3 stands for variant letters A..D, see pir_variant_e
    assign variant_code = id_q.config_variant;

    // shutdown cause clearing order is the host's duty; the flag just obeys write-one

    a_fault_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
        (dev_event.rail_fault || dev_event.die_critical) |=> irq_flags[pir_pkg::BIT_FAULT])
        else $error("fault event did not set flag");

    a_hot_edge_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
        (dev_event.die_hot && !$past(dev_event.die_hot)) |=> irq_flags[pir_pkg::BIT_HOT_DIE])
        else $error("hot crossing did not set flag");

    a_shutdown_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
        dev_event.shutdown |=> irq_flags[pir_pkg::BIT_SHUTDOWN])
        else $error("shutdown event did not set flag");

    a_flags_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
        (irq_flags[pir_pkg::BIT_FAULT] && !(reg_wr && sel_irq && reg_wdata[pir_pkg::BIT_FAULT]))
        |=> irq_flags[pir_pkg::BIT_FAULT])
        else $error("fault flag dropped without write one");

    a_w1c_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && sel_irq && reg_wdata[pir_pkg::BIT_SHUTDOWN] && !dev_event.shutdown)
        |=> !irq_flags[pir_pkg::BIT_SHUTDOWN])
        else $error("write one did not clear shutdown flag");

    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        (irq_flags & ~pir_pkg::IRQ_WR_MASK) == pir_pkg::ZERO_BYTE)
        else $error("reserved flag bit set");

    a_read_low: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_rd && sel_low) |=> reg_rdata == $past(id_q.part_number[7:0]))
        else $error("part number low read wrong");

    a_read_rev: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_rd && sel_rev) |=> reg_rdata[7:6] == $past(id_q.silicon_revision)
        && reg_rdata[5:4] == $past(variant_code)
        && reg_rdata[3:0] == $past(id_q.part_number[11:8]))
        else $error("revision register read wrong");

    a_otp_load: assert property (@(posedge sys_clk) disable iff (!rstn)
        (otp_valid && !id_loaded_q) |=> id_q == $past(otp_id))
        else $error("otp image not captured");

    // flags must not rise without their event
    a_fault_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!irq_flags[pir_pkg::BIT_FAULT] && !dev_event.rail_fault && !dev_event.die_critical)
        |=> !irq_flags[pir_pkg::BIT_FAULT])
        else $error("fault flag set without event");

    a_shutdown_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!irq_flags[pir_pkg::BIT_SHUTDOWN] && !dev_event.shutdown) |=> !irq_flags[pir_pkg::BIT_SHUTDOWN])
        else $error("shutdown flag set without event");

    // the other two flags stick as the fault flag does
    a_shutdown_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
        (irq_flags[pir_pkg::BIT_SHUTDOWN] && !(reg_wr && sel_irq && reg_wdata[pir_pkg::BIT_SHUTDOWN]))
        |=> irq_flags[pir_pkg::BIT_SHUTDOWN])
        else $error("shutdown flag dropped without write one");

    a_hot_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
        (irq_flags[pir_pkg::BIT_HOT_DIE] && !(reg_wr && sel_irq && reg_wdata[pir_pkg::BIT_HOT_DIE]))
        |=> irq_flags[pir_pkg::BIT_HOT_DIE])
        else $error("hot flag dropped without write one");

    // write one clears the fault and hot flags when no event is pending
    a_fault_w1c: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && sel_irq && reg_wdata[pir_pkg::BIT_FAULT] && !dev_event.rail_fault && !dev_event.die_critical)
        |=> !irq_flags[pir_pkg::BIT_FAULT])
        else $error("write one did not clear fault flag");

    a_hot_w1c: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && sel_irq && reg_wdata[pir_pkg::BIT_HOT_DIE] && !hot_rise)
        |=> !irq_flags[pir_pkg::BIT_HOT_DIE])
        else $error("write one did not clear hot flag");

    // an event in the clearing cycle wins over the clear
    a_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && sel_irq && reg_wdata[pir_pkg::BIT_SHUTDOWN] && dev_event.shutdown)
        |=> irq_flags[pir_pkg::BIT_SHUTDOWN])
        else $error("clear beat a shutdown event");

    // read path of the flag byte and of unmapped offsets
    a_read_irq: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_rd && sel_irq) |=> reg_rdata == $past(irq_flags))
        else $error("flag register read wrong");

    a_read_unmapped: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_rd && !sel_low && !sel_rev && !sel_irq) |=> reg_rdata == pir_pkg::ZERO_BYTE)
        else $error("unmapped offset read not zero");

    // read byte stands between reads
    a_rdata_stands: assert property (@(posedge sys_clk) disable iff (!rstn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");

    // id image never changes once captured
    a_id_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
        id_loaded_q |=> $stable(id_q))
        else $error("id image changed after capture");

endmodule

// [verification/pir_host.sv]
// host-side model issuing byte reads and writes into the register bank
// assumes the bench calls its tasks and drives nothing else on these lines
`timescale 1ns/10ps
module pir_host (
    input  wire logic       sys_clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // shutdown cause register of the wider device; this bank ignores the byte
    localparam logic [7:0] ADDR_SHUTDOWN_CAUSE = 8'h05;
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one-cycle strobe; address scrambled after so stale values never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = v;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // flags are cleared by writing ones
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] d;
        xfer(1'b1, a, v, d);
    endtask
    // shutdown cause cleared before the shutdown flag, as the host must
    task automatic clr_shutdown(input logic [7:0] v);
        wr(ADDR_SHUTDOWN_CAUSE, 8'hFF);
        wr(pir_pkg::ADDR_IRQ_FLAGS, v);
    endtask
endmodule

// [verification/pir_regs_tb.sv]
// self-checking bench for the id and flag register bank
// assumes pir_host as the byte-port master, 10 MHz clock
`timescale 1ns/10ps
module pir_regs_tb;
    logic                sys_clk, rstn, otp_valid, reg_wr, reg_rd;
    pir_pkg::pir_id_s    otp_id;
    pir_pkg::pir_event_s dev_event;
    logic [7:0]          reg_addr, reg_wdata, reg_rdata, irq_flags, d;
    logic [1:0]          variant_code;
    int                  miscompares, n_checks;
    pir_regs uut (.sys_clk(sys_clk), .rstn(rstn), .otp_valid(otp_valid), .otp_id(otp_id),
        .dev_event(dev_event), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_flags(irq_flags), .variant_code(variant_code));
    pir_host host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // clock, 100 ns period
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // reset held three cycles, then one otp load with a chosen variant
    task automatic boot(input logic [1:0] v);
        rstn = 1'b0;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        otp_id = {2'h1, v, 12'hA5C}; // part number value is arbitrary
        otp_valid = 1'b1;
        @(negedge sys_clk);
        otp_valid = 1'b0;
    endtask
    // events; die_hot stays as a level, others drop after one cycle
    task automatic ev(input logic [3:0] e);
        @(negedge sys_clk);
        dev_event = e;
        @(negedge sys_clk);
        dev_event = e & 4'h2;
    endtask
    task automatic t_id(input logic [1:0] v);
        boot(v);
        host.xfer(1'b0, pir_pkg::ADDR_PART_LOW, 8'h00, d);
        chk8(d, 8'h5C);
        host.xfer(1'b0, pir_pkg::ADDR_REV_VAR, 8'h00, d);
        chk8(d, {2'h1, v, 4'hA});
        chk8({6'h00, variant_code}, {6'h00, v});
        host.wr(pir_pkg::ADDR_PART_LOW, 8'hFF);
        host.xfer(1'b0, pir_pkg::ADDR_PART_LOW, 8'h00, d);
        chk8(d, 8'h5C);
        $display("id test done, variant %0d", v);
    endtask
    task automatic t_flags();
        boot(2'h0);
        chk8(irq_flags, pir_pkg::IRQ_RESET);
        ev(4'h8);
        chk8(irq_flags, 8'h80);
        host.wr(pir_pkg::ADDR_IRQ_FLAGS, 8'h80);
        chk8(irq_flags, 8'h00);
        ev(4'h4);
        ev(4'h2);
        ev(4'h3);
        chk8(irq_flags, 8'h89);
        host.wr(pir_pkg::ADDR_IRQ_FLAGS, 8'h76);
        host.wr(pir_pkg::ADDR_IRQ_FLAGS, 8'h00);
        host.xfer(1'b0, pir_pkg::ADDR_IRQ_FLAGS, 8'h00, d);
        chk8(d, 8'h89);
        host.clr_shutdown(8'h09);
        chk8(irq_flags, 8'h80);
        host.xfer(1'b0, 8'h7F, 8'h00, d);
        chk8(d, 8'h00);
        $display("flag test done");
    endtask
    // shutdown event in the very cycle of its write-one clear: the event wins
    task automatic t_race();
        dev_event = '0;
        boot(2'h0);
        fork
            host.clr_shutdown(8'h08);
            begin
                repeat (3) @(negedge sys_clk);
                ev(4'h1);
            end
        join
        chk8(irq_flags, 8'h08);
        host.clr_shutdown(8'h08);
        chk8(irq_flags, 8'h00);
        $display("race test done");
    endtask
    // watchdog well beyond the expected run
    initial begin
        #(3000 * 100);
        miscompares++;
        finish_test();
    end
    initial begin
        rstn = 1'b0;
        otp_valid = 1'b0;
        otp_id = '0;
        dev_event = '0;
        miscompares = 0;
        n_checks = 0;
        for (int i = 0; i < 4; i++) t_id(2'(i));
        t_flags();
        t_race();
        finish_test();
    end
endmodule
